/* rtr_relay_tunnel.sv */
// tunnelled read and broadcast write frame interpreter of one relay
// How it works
// - a read with zero controller or relay address is dropped and nothing is sent back.
// - a read request is ctrl, 0x44, relay, aux, start hi/lo, quantity hi/lo, crc lo/hi.
// - aux 0x04 reads the input registers.
// - aux 0x03 reads the holding registers.
// - a good read answers ctrl, 0x44, relay, aux|0x80, 2*N, register words high byte first, crc.
// - a failed read of the right length answers ctrl, 0xC4, relay, aux|0x80, exception code 2 or 3, crc.
// - only write aux 0x06 and 0x10 are accepted with a zero controller or relay address.
// - controller zero and relay zero is applied by every relay everywhere.
// - controller zero and a relay address is applied by that relay on every chain.
// - a controller address and relay zero is applied by every relay of that controller.
// - no relay answers any broadcast write.
// - input 0x08 gives hold current in 0.01 A, input 0x09 gives rms voltage in 1 V.
`include "rtr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rtr_relay_tunnel #(
	parameter int HOLD_DEPTH = 64,
	parameter int BUF_DEPTH  = 256
) (
	input  wire logic                i_clk_sys,
	input  wire logic                i_srst,
	input  wire rtr_pkg::rtr_stream_t i_rx,
	input  wire logic                i_rx_frame_end,
	input  wire logic [7:0]          i_ctrl_id,
	input  wire logic [7:0]          i_relay_id,
	input  wire logic [15:0]         i_hold_current,
	input  wire logic [15:0]         i_rms_voltage,
	input  wire logic                i_tx_ready,
	output var  rtr_pkg::rtr_stream_t o_tx,
	output var  logic                o_busy
);
	import rtr_pkg::*;

	function automatic logic is_read_aux(input logic [7:0] a);
		return (a == `RTR_AUX_RD_HOLD) || (a == `RTR_AUX_RD_INPUT);
	endfunction : is_read_aux

	function automatic logic is_write_aux(input logic [7:0] a);
		return (a == `RTR_AUX_WR_SINGLE) || (a == `RTR_AUX_WR_MULTI);
	endfunction : is_write_aux

	logic [7:0]  rx_buf [BUF_DEPTH];
	rtr_state_t  state_q, state_d;
	rtr_kind_t   kind_q, kind_d;
	rtr_req_t    req_q, req_d, req_w;
	logic [8:0]  cnt_q, cnt_d;
	logic [8:0]  idx_q, idx_d;
	logic [8:0]  len_q, len_d;
	logic [7:0]  widx_q, widx_d;
	logic [7:0]  exc_q, exc_d;
	logic [15:0] hold_current_reading_q;
	logic [15:0] rms_voltage_reading_q;
	rtr_stream_t tx_q, tx_d;
	logic        busy_q;
	logic        rx_take, tx_fire, tx_feed;
	logic [15:0] rx_crc, tx_crc;
	logic        hold_we;
	logic [15:0] hold_waddr, hold_wdata, hold_raddr, hold_rdata;
	logic        crc_ok, bcast, ctrl_hit, relay_hit, ctrl_ok, relay_ok;
	logic        qty_ok, addr_ok, len_ok, wr_go;
	logic [16:0] span_end;
	logic [9:0]  wrn_len;
	logic [8:0]  data_off;
	logic [15:0] rd_val;
	logic [7:0]  tx_byte;
	logic [7:0]  wlo_idx;

	rtr_crc16 u_rx_crc (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_clear   (state_q == ST_EVAL),
		.i_valid   (rx_take),
		.i_byte    (i_rx.data),
		.o_crc     (rx_crc)
	);

	rtr_crc16 u_tx_crc (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_clear   (state_q == ST_EVAL),
		.i_valid   (tx_feed),
		.i_byte    (tx_q.data),
		.o_crc     (tx_crc)
	);

	rtr_hold_regs #(.DEPTH(HOLD_DEPTH)) u_hold (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_we      (hold_we),
		.i_waddr   (hold_waddr),
		.i_wdata   (hold_wdata),
		.i_raddr   (hold_raddr),
		.o_rdata   (hold_rdata)
	);

	// request fields by position
	always_comb begin
		req_w = '{ctrl: rx_buf[0], func: rx_buf[1], relay: rx_buf[2], aux: rx_buf[3],
			addr: {rx_buf[4], rx_buf[5]}, qty: {rx_buf[6], rx_buf[7]}, bcount: rx_buf[8]};
	end

	assign rx_take = (state_q == ST_IDLE) && i_rx.valid && (cnt_q < 9'(BUF_DEPTH));
	assign tx_fire = (state_q == ST_TX_WAIT) && i_tx_ready;
	assign tx_feed = tx_fire && (idx_q < (len_q - 9'h002));

	always_ff @(posedge i_clk_sys) begin
		if (rx_take) begin
			rx_buf[cnt_q[7:0]] <= i_rx.data;
		end
	end

	// frame evaluation terms
	always_comb begin
		crc_ok    = (rx_crc == `RTR_CRC_RESIDUE) && (cnt_q >= `RTR_MIN_FRAME_LEN);
		bcast     = (req_w.ctrl == `RTR_ID_BCAST) || (req_w.relay == `RTR_ID_BCAST);
		ctrl_hit  = (req_w.ctrl == i_ctrl_id);
		relay_hit = (req_w.relay == i_relay_id);
		ctrl_ok   = ctrl_hit || (req_w.ctrl == `RTR_ID_BCAST);
		relay_ok  = relay_hit || (req_w.relay == `RTR_ID_BCAST);
		span_end  = {1'b0, req_w.addr} + {1'b0, req_w.qty};
		wrn_len   = `RTR_WRN_HDR_LEN + {1'b0, req_w.qty[7:0], 1'b0};
		qty_ok    = 1'b1;
		addr_ok   = 1'b1;
		len_ok    = 1'b0;
		if (is_read_aux(req_w.aux)) begin
			len_ok = (cnt_q == `RTR_RD_FRAME_LEN);
			qty_ok = (req_w.qty >= `RTR_RD_QTY_MIN) && (req_w.qty <= `RTR_RD_QTY_MAX);
			if (req_w.aux == `RTR_AUX_RD_INPUT) begin
				addr_ok = (req_w.addr >= `RTR_IN_HOLD_CURRENT)
					&& (span_end <= {1'b0, `RTR_IN_RMS_VOLTAGE} + 17'h0_0001);
			end else begin
				addr_ok = (span_end <= 17'(HOLD_DEPTH));
			end
		end else if (req_w.aux == `RTR_AUX_WR_SINGLE) begin
			len_ok  = (cnt_q == `RTR_WR1_FRAME_LEN);
			addr_ok = (req_w.addr < 16'(HOLD_DEPTH));
		end else if (req_w.aux == `RTR_AUX_WR_MULTI) begin
			len_ok  = (cnt_q >= 9'(`RTR_WRN_HDR_LEN));
			qty_ok  = (req_w.qty >= `RTR_RD_QTY_MIN) && (req_w.qty <= `RTR_WR_QTY_MAX)
				&& (req_w.bcount == {req_w.qty[6:0], 1'b0}) && ({1'b0, cnt_q} == wrn_len);
			addr_ok = (span_end <= 17'(HOLD_DEPTH));
		end
		wr_go = crc_ok && (req_w.func == `RTR_FUNC_TUNNEL) && is_write_aux(req_w.aux)
			&& ctrl_ok && relay_ok && len_ok && qty_ok && addr_ok;
	end

	// register values for the answer
	always_comb begin
		data_off   = idx_q - `RTR_RD_DATA_START;
		hold_raddr = req_q.addr + {8'h00, data_off[8:1]};
		rd_val     = hold_rdata;
		if (req_q.aux == `RTR_AUX_RD_INPUT) begin
			rd_val = 16'h0000;
			if (hold_raddr == `RTR_IN_HOLD_CURRENT) begin
				rd_val = hold_current_reading_q;
			end else if (hold_raddr == `RTR_IN_RMS_VOLTAGE) begin
				rd_val = rms_voltage_reading_q;
			end
		end
		tx_byte = 8'h00;
		if (idx_q == 9'h000) begin
			tx_byte = req_q.ctrl;
		end else if (idx_q == 9'h001) begin
			tx_byte = (kind_q == KIND_EXC) ? `RTR_FUNC_TUNNEL_EXC : `RTR_FUNC_TUNNEL;
		end else if (idx_q == 9'h002) begin
			tx_byte = req_q.relay;
		end else if (idx_q == 9'h003) begin
			tx_byte = req_q.aux | `RTR_AUX_RESP_FLAG;
		end else if (idx_q == len_q - 9'h002) begin
			tx_byte = tx_crc[7:0];
		end else if (idx_q == len_q - 9'h001) begin
			tx_byte = tx_crc[15:8];
		end else if (kind_q == KIND_EXC) begin
			tx_byte = exc_q;
		end else if (kind_q == KIND_ECHO) begin
			tx_byte = rx_buf[idx_q[7:0]];
		end else if (idx_q == 9'h004) begin
			tx_byte = {req_q.qty[6:0], 1'b0};
		end else begin
			tx_byte = data_off[0] ? rd_val[7:0] : rd_val[15:8];
		end
	end

	// holding register write path
	always_comb begin
		wlo_idx    = `RTR_WRN_DATA_START + {widx_q[6:0], 1'b0};
		hold_we    = (state_q == ST_WRITE);
		hold_waddr = req_q.addr + {8'h00, widx_q};
		hold_wdata = {rx_buf[6], rx_buf[7]};
		if (req_q.aux == `RTR_AUX_WR_MULTI) begin
			hold_wdata = {rx_buf[wlo_idx], rx_buf[wlo_idx + 8'h01]};
		end
	end

	// sequencer
	always_comb begin
		state_d = state_q;
		kind_d  = kind_q;
		req_d   = req_q;
		cnt_d   = cnt_q;
		idx_d   = idx_q;
		len_d   = len_q;
		widx_d  = widx_q;
		exc_d   = exc_q;
		tx_d    = tx_q;
		unique case (state_q)
			ST_IDLE: begin
				if (rx_take) begin
					cnt_d = cnt_q + 9'h001;
				end
				if (i_rx_frame_end) begin
					state_d = ST_EVAL;
				end
			end
			ST_EVAL: begin
				req_d   = req_w;
				kind_d  = KIND_NONE;
				idx_d   = 9'h000;
				widx_d  = 8'h00;
				cnt_d   = 9'h000;
				state_d = ST_IDLE;
				if (wr_go) begin
					state_d = ST_WRITE;
					kind_d  = bcast ? KIND_NONE : KIND_ECHO;
					len_d   = `RTR_ECHO_RESP_LEN;
				end else if (crc_ok && (req_w.func == `RTR_FUNC_TUNNEL) && !bcast
						&& ctrl_hit && relay_hit) begin
					kind_d  = KIND_EXC;
					len_d   = `RTR_EXC_RESP_LEN;
					state_d = ST_TX_LOAD;
					if (!is_read_aux(req_w.aux) && !is_write_aux(req_w.aux)) begin
						exc_d = `RTR_EXC_ILL_FUNC;
					end else if (!len_ok) begin
						kind_d  = KIND_NONE;
						state_d = ST_IDLE;
					end else if (!qty_ok) begin
						exc_d = `RTR_EXC_ILL_VALUE;
					end else if (!addr_ok) begin
						exc_d = `RTR_EXC_ILL_ADDR;
					end else begin
						kind_d = KIND_READ;
						len_d  = `RTR_RD_RESP_FIXED + {req_w.qty[7:0], 1'b0};
					end
				end
			end
			ST_WRITE: begin
				widx_d = widx_q + 8'h01;
				if ((req_q.aux == `RTR_AUX_WR_SINGLE) || ({8'h00, widx_d} == req_q.qty)) begin
					state_d = (kind_q == KIND_NONE) ? ST_IDLE : ST_TX_LOAD;
				end
			end
			ST_TX_LOAD: begin
				tx_d    = '{valid: 1'b1, data: tx_byte};
				state_d = ST_TX_WAIT;
			end
			ST_TX_WAIT: begin
				if (i_tx_ready) begin
					tx_d.valid = 1'b0;
					idx_d      = idx_q + 9'h001;
					state_d    = (idx_q == len_q - 9'h001) ? ST_IDLE : ST_TX_LOAD;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_q                <= ST_IDLE;
			kind_q                 <= KIND_NONE;
			req_q                  <= '0;
			cnt_q                  <= 9'h000;
			idx_q                  <= 9'h000;
			len_q                  <= 9'h000;
			widx_q                 <= 8'h00;
			exc_q                  <= 8'h00;
			tx_q                   <= '0;
			busy_q                 <= 1'b0;
			hold_current_reading_q <= 16'h0000;
			rms_voltage_reading_q  <= 16'h0000;
		end else begin
			state_q                <= state_d;
			kind_q                 <= kind_d;
			req_q                  <= req_d;
			cnt_q                  <= cnt_d;
			idx_q                  <= idx_d;
			len_q                  <= len_d;
			widx_q                 <= widx_d;
			exc_q                  <= exc_d;
			tx_q                   <= tx_d;
			busy_q                 <= (state_d != ST_IDLE);
			hold_current_reading_q <= i_hold_current;
			rms_voltage_reading_q  <= i_rms_voltage;
		end
	end

	assign o_tx   = tx_q;
	assign o_busy = busy_q;

	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	sequence s_eval_bcast_read;
		(state_q == ST_EVAL) && is_read_aux(req_w.aux) && bcast;
	endsequence

	sequence s_eval_bcast_write;
		(state_q == ST_EVAL) && wr_go && bcast;
	endsequence

	sequence s_eval_wr_single;
		(state_q == ST_EVAL) && wr_go && (req_w.aux == `RTR_AUX_WR_SINGLE);
	endsequence

	a_bcast_read_drop : assert property (s_eval_bcast_read |=> (state_q == ST_IDLE) && !o_tx.valid)
		else $error("broadcast read not dropped");
	a_resp_func_byte : assert property (o_tx.valid && (idx_q == 9'h001) |->
		o_tx.data == ((kind_q == KIND_EXC) ? `RTR_FUNC_TUNNEL_EXC : `RTR_FUNC_TUNNEL))
		else $error("wrong function byte in answer");
	a_resp_aux_flag : assert property (o_tx.valid && (idx_q == 9'h003) |->
		o_tx.data == (req_q.aux | `RTR_AUX_RESP_FLAG))
		else $error("aux byte lacks response flag");
	a_read_byte_count : assert property (o_tx.valid && (kind_q == KIND_READ) && (idx_q == 9'h004) |->
		(o_tx.data == {req_q.qty[6:0], 1'b0}) && (len_q == {req_q.qty[7:0], 1'b0} + 9'h007))
		else $error("read byte count wrong");
	a_exc_code_range : assert property (o_tx.valid && (kind_q == KIND_EXC) && (idx_q == 9'h004) |->
		(o_tx.data >= 8'h01) && (o_tx.data <= 8'h04))
		else $error("exception code out of range");
	a_bcast_write_quiet : assert property (s_eval_bcast_write |=> (kind_q == KIND_NONE)
		##0 (!o_tx.valid throughout (state_q == ST_WRITE) [*1]))
		else $error("broadcast write set up an answer");
	a_no_answer_kind : assert property (o_tx.valid |-> kind_q != KIND_NONE)
		else $error("answer sent without a response kind");
	a_bad_crc_drop : assert property ((state_q == ST_EVAL) && !crc_ok |=> state_q == ST_IDLE)
		else $error("frame with bad check not dropped");
	a_write_applied : assert property (s_eval_wr_single |=>
		hold_we && (hold_waddr == $past(req_w.addr)) ##1 !hold_we)
		else $error("single write not applied once");
	a_input_map : assert property ((state_q == ST_TX_WAIT) && (kind_q == KIND_READ)
		&& (req_q.aux == `RTR_AUX_RD_INPUT) && (hold_raddr == `RTR_IN_RMS_VOLTAGE) && (idx_q > 9'h004)
		&& (idx_q < len_q - 9'h002) |-> rd_val == $past(i_rms_voltage))
		else $error("input register map wrong");

endmodule : rtr_relay_tunnel
`default_nettype wire

/* rtr_defs.svh */
// constants for the relay tunnel frame interpreter
`ifndef RTR_DEFS_SVH
`define RTR_DEFS_SVH

`define RTR_FUNC_TUNNEL      8'h44
`define RTR_FUNC_TUNNEL_EXC  8'hC4
`define RTR_AUX_RD_HOLD      8'h03
`define RTR_AUX_RD_INPUT     8'h04
`define RTR_AUX_WR_SINGLE    8'h06
`define RTR_AUX_WR_MULTI     8'h10
`define RTR_AUX_RESP_FLAG    8'h80
`define RTR_ID_BCAST         8'h00

`define RTR_RD_QTY_MIN       16'h0001
`define RTR_RD_QTY_MAX       16'h007C
`define RTR_WR_QTY_MAX       16'h007A

`define RTR_IN_HOLD_CURRENT  16'h0008
`define RTR_IN_RMS_VOLTAGE   16'h0009

`define RTR_EXC_ILL_FUNC     8'h01
`define RTR_EXC_ILL_ADDR     8'h02
`define RTR_EXC_ILL_VALUE    8'h03

`define RTR_CRC_INIT         16'hFFFF
`define RTR_CRC_POLY         16'hA001
`define RTR_CRC_RESIDUE      16'h0000

`define RTR_MIN_FRAME_LEN    9'h004
`define RTR_RD_FRAME_LEN     9'h00A
`define RTR_WR1_FRAME_LEN    9'h00A
`define RTR_WRN_HDR_LEN      10'h00B
`define RTR_EXC_RESP_LEN     9'h007
`define RTR_ECHO_RESP_LEN    9'h00A
`define RTR_RD_RESP_FIXED    9'h007
`define RTR_RD_DATA_START    9'h005
`define RTR_WRN_DATA_START   8'h09

`endif

/* rtr_pkg.sv */
// types shared by the relay tunnel frame interpreter
`default_nettype none
package rtr_pkg;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} rtr_stream_t;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  func;
		logic [7:0]  relay;
		logic [7:0]  aux;
		logic [15:0] addr;
		logic [15:0] qty;
		logic [7:0]  bcount;
	} rtr_req_t;

	typedef enum logic [2:0] {ST_IDLE, ST_EVAL, ST_WRITE, ST_TX_LOAD, ST_TX_WAIT} rtr_state_t;

	typedef enum logic [1:0] {KIND_NONE, KIND_READ, KIND_EXC, KIND_ECHO} rtr_kind_t;

endpackage : rtr_pkg
`default_nettype wire

/* rtr_crc16.sv */
// frame check accumulator, one byte per strobe
`include "rtr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rtr_crc16 (
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	input  wire logic        i_clear,
	input  wire logic        i_valid,
	input  wire logic [7:0]  i_byte,
	output var  logic [15:0] o_crc
);
	import rtr_pkg::*;

	logic [15:0] crc_q;
	logic [15:0] crc_d;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `RTR_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	always_comb begin
		crc_d = crc_q;
		if (i_clear) begin
			crc_d = `RTR_CRC_INIT;
		end else if (i_valid) begin
			crc_d = crc_step(crc_q, i_byte);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			crc_q <= `RTR_CRC_INIT;
		end else begin
			crc_q <= crc_d;
		end
	end

	assign o_crc = crc_q;

	a_crc_clear_init : assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_clear |=> crc_q == `RTR_CRC_INIT)
		else $error("crc not reloaded after clear");

endmodule : rtr_crc16
`default_nettype wire

/* rtr_hold_regs.sv */
// relay holding register array
`timescale 1ns/1ps
`default_nettype none
module rtr_hold_regs #(
	parameter int DEPTH = 64
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	input  wire logic        i_we,
	input  wire logic [15:0] i_waddr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [15:0] i_raddr,
	output var  logic [15:0] o_rdata
);
	localparam int AW = $clog2(DEPTH);

	logic [15:0] mem_q [DEPTH];

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= 16'h0000;
			end
		end else if (i_we && (i_waddr < 16'(DEPTH))) begin
			mem_q[i_waddr[AW-1:0]] <= i_wdata;
		end
	end

	always_comb begin
		o_rdata = 16'h0000;
		if (i_raddr < 16'(DEPTH)) begin
			o_rdata = mem_q[i_raddr[AW-1:0]];
		end
	end

endmodule : rtr_hold_regs
`default_nettype wire

/* rtr_master_model.sv */
// bus master model that sends request frames and takes the answers
`timescale 1ns/1ps
`default_nettype none
module rtr_master_model (
	input  wire logic                 i_clk_sys,
	input  wire rtr_pkg::rtr_stream_t i_tx,
	output var  rtr_pkg::rtr_stream_t o_rx,
	output var  logic                 o_frame_end,
	output var  logic                 o_tx_ready
);
	import rtr_pkg::*;
	typedef logic [7:0] rtr_mq_t [$];
	logic       slow   = 1'b0;
	logic [1:0] pace_q = 2'h0;

	initial begin
		o_rx        = '0;
		o_frame_end = 1'b0;
		o_tx_ready  = 1'b0;
	end

	// prompt taker, or one take in three cycles
	always @(negedge i_clk_sys) begin
		pace_q     <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
		o_tx_ready <= !slow || (pace_q == 2'h0);
	end

	function automatic logic [15:0] crc16(input rtr_mq_t b);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
			end
		end
		return c;
	endfunction : crc16

	// callers keep ids in range and broadcast both reads and writes, on purpose
	task automatic send_frame(input rtr_mq_t b, input logic bad_crc);
		logic [15:0] c;
		c = crc16(b) ^ {15'h0000, bad_crc};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		foreach (b[i]) begin
			@(negedge i_clk_sys);
			o_rx <= '{valid: 1'b1, data: b[i]};
			@(negedge i_clk_sys);
			o_rx <= '{valid: 1'b0, data: ~b[i]};
		end
		@(negedge i_clk_sys);
		o_frame_end <= 1'b1;
		@(negedge i_clk_sys);
		o_frame_end <= 1'b0;
	endtask : send_frame

	// byte taken at the rising edge after a settled valid and ready
	task automatic get_byte(output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d  = 8'h00;
		for (int n = 0; n < 200 && !ok; n++) begin
			@(negedge i_clk_sys);
			#1;
			if (i_tx.valid === 1'b1 && o_tx_ready === 1'b1) begin
				d  = i_tx.data;
				ok = 1'b1;
			end
		end
	endtask : get_byte
endmodule : rtr_master_model
`default_nettype wire

/* rtr_relay_tunnel_tb_top.sv */
// testbench of the relay tunnel frame interpreter
`timescale 1ns/1ps
`default_nettype none
module rtr_relay_tunnel_tb_top;
	import rtr_pkg::*;
	typedef logic [7:0] rtr_tbq_t [$];
	logic        i_clk_sys  = 1'b0;
	logic        i_srst     = 1'b1;
	rtr_stream_t rx;
	rtr_stream_t tx;
	logic        frame_end;
	logic        tx_ready;
	logic        busy;
	logic [15:0] hold_cur   = 16'h03E8;
	logic [15:0] rms_volt   = 16'h00E6;
	logic [15:0] hexp [128];
	logic [7:0]  zc [3]     = '{8'h00, 8'h02, 8'h00};
	logic [7:0]  zr [3]     = '{8'h05, 8'h00, 8'h00};
	int          err_count  = 0;
	int          num_checks = 0;
	rtr_tbq_t    q;
	rtr_tbq_t    none;

	always #10 i_clk_sys = ~i_clk_sys;

	rtr_relay_tunnel #(.HOLD_DEPTH(128), .BUF_DEPTH(256)) uut (
		.i_clk_sys     (i_clk_sys),
		.i_srst        (i_srst),
		.i_rx          (rx),
		.i_rx_frame_end(frame_end),
		.i_ctrl_id     (8'h02),
		.i_relay_id    (8'h05),
		.i_hold_current(hold_cur),
		.i_rms_voltage (rms_volt),
		.i_tx_ready    (tx_ready),
		.o_tx          (tx),
		.o_busy        (busy)
	);

	rtr_master_model mst (
		.i_clk_sys  (i_clk_sys),
		.i_tx       (tx),
		.o_rx       (rx),
		.o_frame_end(frame_end),
		.o_tx_ready (tx_ready)
	);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	// one request, then the answer bytes with their check, or silence
	task automatic xact(input rtr_tbq_t req, input rtr_tbq_t exp, input logic bad);
		logic [15:0] c;
		logic [7:0]  d;
		logic        ok;
		mst.send_frame(req, bad);
		if (exp.size() == 0) begin
			for (int n = 0; n < 40; n++) begin
				@(negedge i_clk_sys);
				chk({15'h0000, tx.valid}, 16'h0000, "silent");
			end
		end else begin
			c = mst.crc16(exp);
			exp.push_back(c[7:0]);
			exp.push_back(c[15:8]);
			foreach (exp[i]) begin
				mst.get_byte(d, ok);
				if (!ok) begin
					chk(16'h0000, 16'h0001, "answer timeout");
					final_report();
				end else begin
					chk({8'h00, d}, {8'h00, exp[i]}, "answer byte");
				end
			end
		end
		for (int n = 0; n < 20 && busy !== 1'b0; n++) begin
			@(negedge i_clk_sys);
		end
		chk({15'h0000, busy}, 16'h0000, "idle after frame");
		chk({15'h0000, tx.valid}, 16'h0000, "no extra byte");
		if (busy !== 1'b0) begin
			final_report();
		end
	endtask : xact

	initial begin
		foreach (hexp[i]) hexp[i] = 16'h0000;
		repeat (2) @(negedge i_clk_sys);
		i_srst = 1'b0;
		// input registers, prompt then slow taker
		xact('{8'h02, 8'h44, 8'h05, 8'h04, 8'h00, 8'h08, 8'h00, 8'h02},
			'{8'h02, 8'h44, 8'h05, 8'h84, 8'h04, 8'h03, 8'hE8, 8'h00, 8'hE6}, 1'b0);
		mst.slow = 1'b1;
		hold_cur = 16'h0102;
		rms_volt = 16'hFEDC;
		xact('{8'h02, 8'h44, 8'h05, 8'h04, 8'h00, 8'h08, 8'h00, 8'h02},
			'{8'h02, 8'h44, 8'h05, 8'h84, 8'h04, 8'h01, 8'h02, 8'hFE, 8'hDC}, 1'b0);
		mst.slow = 1'b0;
		// reads with a zero address in either place
		for (int i = 0; i < 6; i++) begin
			xact('{zc[i%3], 8'h44, zr[i%3], (i < 3) ? 8'h04 : 8'h03, 8'h00, 8'h08, 8'h00, 8'h01}, none, 1'b0);
		end
		// other relay, other function, broken check
		xact('{8'h02, 8'h44, 8'h06, 8'h04, 8'h00, 8'h08, 8'h00, 8'h01}, none, 1'b0);
		xact('{8'h02, 8'h43, 8'h05, 8'h04, 8'h00, 8'h08, 8'h00, 8'h01}, none, 1'b0);
		xact('{8'h02, 8'h44, 8'h05, 8'h04, 8'h00, 8'h08, 8'h00, 8'h01}, none, 1'b1);
		// exception answers
		xact('{8'h02, 8'h44, 8'h05, 8'h05, 8'h00, 8'h08, 8'h00, 8'h01},
			'{8'h02, 8'hC4, 8'h05, 8'h85, 8'h01}, 1'b0);
		xact('{8'h02, 8'h44, 8'h05, 8'h04, 8'h00, 8'h08, 8'h00, 8'h00},
			'{8'h02, 8'hC4, 8'h05, 8'h84, 8'h03}, 1'b0);
		xact('{8'h02, 8'h44, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7D},
			'{8'h02, 8'hC4, 8'h05, 8'h83, 8'h03}, 1'b0);
		xact('{8'h02, 8'h44, 8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01},
			'{8'h02, 8'hC4, 8'h05, 8'h84, 8'h02}, 1'b0);
		// addressed write, then the broadcast forms
		xact('{8'h02, 8'h44, 8'h05, 8'h06, 8'h00, 8'h03, 8'h12, 8'h34},
			'{8'h02, 8'h44, 8'h05, 8'h86, 8'h00, 8'h03, 8'h12, 8'h34}, 1'b0);
		xact('{8'h00, 8'h44, 8'h00, 8'h06, 8'h00, 8'h04, 8'hA5, 8'hA5}, none, 1'b0);
		xact('{8'h00, 8'h44, 8'h05, 8'h06, 8'h00, 8'h05, 8'hB1, 8'hB1}, none, 1'b0);
		xact('{8'h02, 8'h44, 8'h00, 8'h10, 8'h00, 8'h06, 8'h00, 8'h02, 8'h04,
			8'hC1, 8'hC1, 8'hC2, 8'hC2}, none, 1'b0);
		xact('{8'h00, 8'h44, 8'h07, 8'h06, 8'h00, 8'h08, 8'hDE, 8'hAD}, none, 1'b0);
		xact('{8'h03, 8'h44, 8'h00, 8'h06, 8'h00, 8'h09, 8'hBE, 8'hEF}, none, 1'b0);
		// addressed multiple write echo, write outside the holding array
		xact('{8'h02, 8'h44, 8'h05, 8'h10, 8'h00, 8'h0A, 8'h00, 8'h01, 8'h02, 8'h77, 8'h88},
			'{8'h02, 8'h44, 8'h05, 8'h90, 8'h00, 8'h0A, 8'h00, 8'h01}, 1'b0);
		xact('{8'h02, 8'h44, 8'h05, 8'h06, 8'h00, 8'h80, 8'h00, 8'h01},
			'{8'h02, 8'hC4, 8'h05, 8'h86, 8'h02}, 1'b0);
		hexp[10] = 16'h7788;
		hexp[3] = 16'h1234;
		hexp[4] = 16'hA5A5;
		hexp[5] = 16'hB1B1;
		hexp[6] = 16'hC1C1;
		hexp[7] = 16'hC2C2;
		// largest holding read shows which writes landed
		q = '{8'h02, 8'h44, 8'h05, 8'h83, 8'hF8};
		for (int i = 0; i < 124; i++) begin
			q.push_back(hexp[i][15:8]);
			q.push_back(hexp[i][7:0]);
		end
		xact('{8'h02, 8'h44, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7C}, q, 1'b0);
		final_report();
	end
endmodule : rtr_relay_tunnel_tb_top
`default_nettype wire
